//--- hw/free_running_capture_compare_timer.sv
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "frt_regs.svh"
// Overview of operation
// - Two select bits pick divide-by-2, 8, 32 or the external pin as count clock.
// - External source counts every rising edge seen on the external clock pin.
// - Buffer-enable B makes capture D the buffer of capture B.
// - Mask-mode bit makes capture D ignore its pin during a mask window.
// - Add-mode bit makes compare A run with the two increment registers.
// - Capture bank bit maps captures A-C or increments and mask width onto shared words.
// - Compare bank bit picks compare A or B at their shared word.
// - Output enables gate each compare result onto its pin.
// - Level bits set the match level; level A is ignored in add mode.
// - Output control register resets to zero.
// - Halt bit set freezes the timer after the write; clearing resumes it.
// - Halt register resets to 3fff, leaving the timer stopped.
// - Counter steps by exactly one per selected clock period.
// - Compare match drives the matching level bit onto the compare pin; add mode toggles pin A instead.
// - Compare match A can clear the counter to zero.
// - Each capture pin triggers on rising edge if its select is 1, else falling.
// - A capture arriving during a read of its register is postponed one cycle.
// - Buffer mode with opposite A and C selects captures both edges of pin A.
// - A buffer channel pin sets its flag but loads no counter value.
// - Buffered capture waits one cycle while either register of the pair is read.
// - Clear-on-match-A bit, reset zero, enables the compare A counter clear.
// - Add mode adds rise and fall increments to compare A alternately on match.
// - Flags set by hardware only; software reads one, then writes zero to clear.
module free_running_capture_compare_timer (
   input  wire logic          i_core_clk,
   input  wire logic          i_rst,
   input  wire frt_pkg::addr_t i_addr,
   input  wire frt_pkg::word_t i_wdata,
   input  wire logic          i_wr,
   input  wire logic          i_rd,
   output frt_pkg::word_t     o_rdata,
   input  wire logic          i_capture_in_pin_a,
   input  wire logic          i_capture_in_pin_b,
   input  wire logic          i_capture_in_pin_c,
   input  wire logic          i_capture_in_pin_d,
   input  wire logic          i_ext_count_clock_pin,
   output logic               o_compare_out_pin_a,
   output logic               o_compare_out_pin_b
);
   import frt_pkg::*;

   localparam timer_state_t ST_RESET = '{halt: `HALT_RESET, setup: `SETUP_RESET,
                                         octl: `OUT_CTRL_RESET, default: '0};

   timer_state_t s_r;
   timer_state_t s_nxt;
   logic [4:0]   pins;
   logic [4:0]   rise;
   logic [4:0]   fall;
   logic [3:0]   esel;
   logic [3:0]   ev;
   logic [3:0]   rdcap;
   logic [3:0]   blk;
   logic [3:0]   req;
   logic [3:0]   go;
   logic         run;
   logic         tick;
   logic         bufa;
   logic         bufb;
   logic         add_mode;
   logic         mask_mode;
   logic         bank;
   logic         wr_cnt;
   logic         wr_cmp_a;
   logic         wr_cmp_b;
   logic         wr_status;
   logic         rd_status;
   logic         match_a;
   logic         match_b;
   logic         clear_a;
   logic         wrap;
   logic         masked;
   word_t        mask_end;
   flags_t       fset;
   flags_t       fclr;

   // Pin edges; index 4 is the external count clock.
   assign pins = {i_ext_count_clock_pin, i_capture_in_pin_d, i_capture_in_pin_c,
                  i_capture_in_pin_b, i_capture_in_pin_a};

   for (genvar g = 0; g < 5; g++)
   begin : g_edge
      frt_edge_detect u_edge (
         .i_core_clk (i_core_clk),
         .i_rst      (i_rst),
         .i_sig      (pins[g]),
         .o_rise     (rise[g]),
         .o_fall     (fall[g])
      );
   end

   // Count clock source; the prescaler stands still while halted.
   frt_prescaler #(
      .DIV_W (5)
   ) u_presc (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_en       (run),
      .i_sel      (s_r.setup[`SET_CKS_HI:`SET_CKS_LO]),
      .i_ext_rise (rise[4]),
      .o_tick     (tick)
   );

   // Mode bits and decodes.
   assign run       = ~s_r.halt[`HALT_BIT];
   assign bufa      = s_r.setup[`SET_BUF_A];
   assign bufb      = s_r.setup[`SET_BUF_B];
   assign add_mode  = s_r.octl[`OC_ADD_A];
   assign mask_mode = s_r.octl[`OC_MASK_D];
   assign bank      = s_r.octl[`OC_CAP_BANK];
   assign esel      = {s_r.setup[`SET_EDGE_D], s_r.setup[`SET_EDGE_C],
                       s_r.setup[`SET_EDGE_B], s_r.setup[`SET_EDGE_A]};
   assign wr_cnt    = i_wr & (i_addr == `ADDR_COUNTER);
   assign wr_cmp_a  = i_wr & (i_addr == `ADDR_COMPARE) & ~s_r.octl[`OC_CMP_BANK];
   assign wr_cmp_b  = i_wr & (i_addr == `ADDR_COMPARE) & s_r.octl[`OC_CMP_BANK];
   assign wr_status = i_wr & (i_addr == `ADDR_STATUS);
   assign rd_status = i_rd & (i_addr == `ADDR_STATUS);

   // Reads that postpone a capture; shared words only count in the capture bank.
   assign rdcap[0] = i_rd & (i_addr == `ADDR_CAP_A) & ~bank;
   assign rdcap[1] = i_rd & (i_addr == `ADDR_CAP_B) & ~bank;
   assign rdcap[2] = i_rd & (i_addr == `ADDR_CAP_C) & ~bank;
   assign rdcap[3] = i_rd & (i_addr == `ADDR_CAP_D);
   assign blk = rdcap | {bufb & rdcap[1], bufa & rdcap[0], bufb & rdcap[3], bufa & rdcap[2]};

   // Capture events; in buffer mode pin A also answers to the C edge select.
   assign ev[0] = run & ((esel[0] ? rise[0] : fall[0]) |
                         (bufa & (esel[2] ? rise[0] : fall[0])));
   assign ev[1] = run & (esel[1] ? rise[1] : fall[1]);
   assign ev[2] = run & (esel[2] ? rise[2] : fall[2]);
   assign ev[3] = run & (esel[3] ? rise[3] : fall[3]) & ~masked;
   assign req   = ev | s_r.pend;
   assign go    = req & ~blk;

   // Mask window for capture D ends when the counter reaches capture D plus twice the width.
   assign masked   = mask_mode & s_r.mask_on;
   assign mask_end = s_r.capture_reg_d + {s_r.maskw[14:0], 1'b0};

   // A match is taken on the last count of the matching value; a write in the same cycle wins.
   assign match_a = tick & (s_r.cnt == s_r.compare_reg_a) & ~wr_cmp_a;
   assign match_b = tick & (s_r.cnt == s_r.compare_reg_b) & ~wr_cmp_b;
   assign clear_a = match_a & s_r.clr_a;
   assign wrap    = tick & (s_r.cnt == 16'hffff) & ~clear_a & ~wr_cnt;

   // Flag sources in status bit order A, B, C, D, compare A, compare B, wrap.
   assign fset = {go[0], go[1], go[2], go[3], match_a, match_b, wrap};
   assign fclr = wr_status ? (s_r.armed & ~i_wdata[7:1]) : 7'h00;

   // Next state of the whole timer.
   always_comb
   begin
      s_nxt      = s_r;
      s_nxt.pend = req & blk;

      // Counter: clear beats write, write beats increment.
      if (clear_a)
         s_nxt.cnt = 16'h0000;
      else if (wr_cnt)
         s_nxt.cnt = i_wdata;
      else if (tick)
         s_nxt.cnt = s_r.cnt + 16'h0001;

      // Captures; the buffer takes the old primary value first.
      if (go[0])
      begin
         s_nxt.capture_reg_a = s_r.cnt;
         if (bufa)
            s_nxt.capture_reg_c = s_r.capture_reg_a;
      end
      if (go[2] & ~bufa)
         s_nxt.capture_reg_c = s_r.cnt;
      if (go[1])
      begin
         s_nxt.capture_reg_b = s_r.cnt;
         if (bufb)
            s_nxt.capture_reg_d = s_r.capture_reg_b;
      end
      if (go[3] & ~bufb)
         s_nxt.capture_reg_d = s_r.cnt;

      // Mask window.
      if (~mask_mode)
         s_nxt.mask_on = 1'b0;
      else if (go[3] & (s_r.maskw != 16'h0000))
         s_nxt.mask_on = 1'b1;
      else if (s_r.mask_on & (s_r.cnt == mask_end))
         s_nxt.mask_on = 1'b0;

      // Compare pins; add mode alternates the level and steps compare A.
      if (match_a)
      begin
         if (add_mode)
         begin
            s_nxt.pin_a = ~s_r.pin_a;
            s_nxt.compare_reg_a  = s_r.compare_reg_a + (s_r.pin_a ? s_r.fall : s_r.rise);
         end
         else
            s_nxt.pin_a = s_r.octl[`OC_LVL_A];
      end
      if (match_b)
         s_nxt.pin_b = s_r.octl[`OC_LVL_B];

      // Flags: a set in the same cycle as a clear wins.
      s_nxt.flags = (s_r.flags & ~fclr) | fset;
      if (wr_status)
         s_nxt.armed = 7'h00;
      else if (rd_status)
         s_nxt.armed = s_r.armed | s_r.flags;

      // Register writes.
      if (i_wr)
      begin
         unique case (i_addr)
            `ADDR_COMPARE:
               if (s_r.octl[`OC_CMP_BANK])
                  s_nxt.compare_reg_b = i_wdata;
               else
                  s_nxt.compare_reg_a = i_wdata;
            `ADDR_CAP_A:
               if (bank)
                  s_nxt.rise = i_wdata;
            `ADDR_CAP_B:
               if (bank)
                  s_nxt.fall = i_wdata;
            `ADDR_CAP_C:
               if (bank)
                  s_nxt.maskw = i_wdata;
            `ADDR_SETUP:    s_nxt.setup = i_wdata[7:0];
            `ADDR_OUT_CTRL: s_nxt.octl = i_wdata[7:0];
            `ADDR_STATUS:   s_nxt.clr_a = i_wdata[`ST_CLR_A];
            `ADDR_HALT:     s_nxt.halt = i_wdata;
            default:        s_nxt.halt = s_r.halt;
         endcase
      end

      // Read data stand in the cycle after the strobe; unmapped words read zero.
      s_nxt.rdata = 16'h0000;
      if (i_rd)
      begin
         unique case (i_addr)
            `ADDR_COUNTER:  s_nxt.rdata = s_r.cnt;
            `ADDR_COMPARE:  s_nxt.rdata = s_r.octl[`OC_CMP_BANK] ? s_r.compare_reg_b : s_r.compare_reg_a;
            `ADDR_CAP_A:    s_nxt.rdata = bank ? s_r.rise : s_r.capture_reg_a;
            `ADDR_CAP_B:    s_nxt.rdata = bank ? s_r.fall : s_r.capture_reg_b;
            `ADDR_CAP_C:    s_nxt.rdata = bank ? s_r.maskw : s_r.capture_reg_c;
            `ADDR_CAP_D:    s_nxt.rdata = s_r.capture_reg_d;
            `ADDR_SETUP:    s_nxt.rdata = {8'h00, s_r.setup};
            `ADDR_OUT_CTRL: s_nxt.rdata = {8'h00, s_r.octl};
            `ADDR_STATUS:   s_nxt.rdata = {8'h00, s_r.flags, s_r.clr_a};
            `ADDR_HALT:     s_nxt.rdata = s_r.halt;
            default:        s_nxt.rdata = 16'h0000;
         endcase
      end
   end

   // One register for all state; reset covers output control and the halt word.
   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
         s_r <= ST_RESET;
      else
         s_r <= s_nxt;
   end

   // The pins idle low while disabled, which keeps the board quiet after reset.
   assign o_compare_out_pin_a = s_r.octl[`OC_OE_A] & s_r.pin_a;
   assign o_compare_out_pin_b = s_r.octl[`OC_OE_B] & s_r.pin_b;
   assign o_rdata             = s_r.rdata;

   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_rst);

   sequence s_blocked_a;
      req[0] && blk[0];
   endsequence

   sequence s_free_a;
      !blk[0] && !ev[0];
   endsequence

   chk_count_step: assert property (tick && !clear_a && !wr_cnt |=> s_r.cnt == $past(s_r.cnt) + 16'h0001)
      else $error("counter did not step by one");
   chk_ext_edge: assert property (run && s_r.setup[1:0] == 2'h3 && rise[4] |-> tick)
      else $error("external edge gave no increment");
   chk_halt_freeze: assert property (!run && !wr_cnt |=> $stable(s_r.cnt))
      else $error("counter moved while halted");
   chk_clear_match: assert property (match_a && s_r.clr_a |=> s_r.cnt == 16'h0000)
      else $error("match A did not clear the counter");
   chk_level_a: assert property (match_a && !add_mode |=> s_r.pin_a == $past(s_r.octl[`OC_LVL_A]))
      else $error("pin A level wrong after match");
   chk_level_b: assert property (match_b && s_r.octl[2] ##1 s_r.octl[2] |-> o_compare_out_pin_b == $past(s_r.octl[0]))
      else $error("pin B level wrong after match");
   chk_out_gate: assert property (!s_r.octl[`OC_OE_A] |-> !o_compare_out_pin_a)
      else $error("pin A driven while disabled");
   chk_add_step: assert property (match_a && add_mode |=> s_r.compare_reg_a == $past(s_r.compare_reg_a) + ($past(s_r.pin_a) ? $past(s_r.fall) : $past(s_r.rise)))
      else $error("compare A not stepped by increment");
   chk_cap_delay: assert property (s_blocked_a ##1 s_free_a |=> s_r.capture_reg_a == $past(s_r.cnt))
      else $error("postponed capture A lost");
   chk_buffer_shift: assert property (go[0] && bufa |=> s_r.capture_reg_c == $past(s_r.capture_reg_a) && s_r.flags[6])
      else $error("buffer did not take old capture A");
   chk_buffer_noload: assert property (bufa && !go[0] |=> $stable(s_r.capture_reg_c))
      else $error("buffer C loaded by its own pin");
   chk_flag_set_wins: assert property (|(fset & fclr) |=> |(s_r.flags & $past(fset & fclr)))
      else $error("flag set lost to a clear");
   chk_mask_block: assert property (masked |-> !ev[3])
      else $error("capture D taken inside mask window");
endmodule
`default_nettype wire

//--- hw/frt_edge_detect.sv
`timescale 1ns/10ps
`default_nettype none
module frt_edge_detect (
   input  wire logic i_core_clk,
   input  wire logic i_rst,
   input  wire logic i_sig,
   output logic      o_rise,
   output logic      o_fall
);
   import frt_pkg::*;

   edge_state_t s_r;
   edge_state_t s_nxt;

   // The previous sample always follows the pin, so no stale edge appears after a halt.
   always_comb
   begin
      s_nxt      = s_r;
      s_nxt.prev = i_sig;
   end

   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   assign o_rise = i_sig & ~s_r.prev;
   assign o_fall = ~i_sig & s_r.prev;
endmodule
`default_nettype wire

//--- hw/frt_pkg.sv
`default_nettype none
package frt_pkg;
   typedef logic [15:0] word_t;
   typedef logic [3:0]  addr_t;
   typedef logic [6:0]  flags_t;

   typedef struct packed {
      word_t      cnt;
      word_t      compare_reg_a;
      word_t      compare_reg_b;
      word_t      rise;
      word_t      fall;
      word_t      maskw;
      word_t      capture_reg_a;
      word_t      capture_reg_b;
      word_t      capture_reg_c;
      word_t      capture_reg_d;
      logic [7:0] setup;
      logic [7:0] octl;
      word_t      halt;
      flags_t     flags;
      flags_t     armed;
      logic       clr_a;
      logic [3:0] pend;
      logic       mask_on;
      logic       pin_a;
      logic       pin_b;
      word_t      rdata;
   } timer_state_t;

   typedef struct packed {
      logic prev;
   } edge_state_t;

   typedef struct packed {
      logic [4:0] div;
      logic       prev;
   } presc_state_t;
endpackage
`default_nettype wire

//--- hw/frt_prescaler.sv
`timescale 1ns/10ps
`default_nettype none
`include "frt_regs.svh"
module frt_prescaler #(
   parameter int DIV_W = 5
) (
   input  wire logic       i_core_clk,
   input  wire logic       i_rst,
   input  wire logic       i_en,
   input  wire logic [1:0] i_sel,
   input  wire logic       i_ext_rise,
   output logic            o_tick
);
   import frt_pkg::*;

   presc_state_t s_r;
   presc_state_t s_nxt;
   logic         tap;

   // Taps for the divide-by-2, 8 and 32 clocks.
   always_comb
   begin
      unique case (i_sel)
         2'h0:    tap = s_r.div[0];
         2'h1:    tap = s_r.div[2];
         default: tap = s_r.div[DIV_W-1];
      endcase
   end

   // A falling tap is the increment; a select change can look like one, as on the real part.
   always_comb
   begin
      s_nxt      = s_r;
      s_nxt.prev = tap;
      if (i_en)
         s_nxt.div = s_r.div + 5'h1;
   end

   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   assign o_tick = i_en & ((i_sel == `CKS_EXT) ? i_ext_rise : (s_r.prev & ~tap));
endmodule
`default_nettype wire

//--- hw/frt_regs.svh
`ifndef FRT_REGS_SVH
`define FRT_REGS_SVH
// Word addresses on the register port.
`define ADDR_COUNTER  4'h0
`define ADDR_COMPARE  4'h1
`define ADDR_CAP_A    4'h2
`define ADDR_CAP_B    4'h3
`define ADDR_CAP_C    4'h4
`define ADDR_CAP_D    4'h5
`define ADDR_SETUP    4'h6
`define ADDR_OUT_CTRL 4'h7
`define ADDR_STATUS   4'h8
`define ADDR_HALT     4'h9
// Fields of timer_setup_reg.
`define SET_EDGE_A 7
`define SET_EDGE_B 6
`define SET_EDGE_C 5
`define SET_EDGE_D 4
`define SET_BUF_A  3
`define SET_BUF_B  2
`define SET_CKS_HI 1
`define SET_CKS_LO 0
// Fields of compare_output_control.
`define OC_MASK_D   7
`define OC_ADD_A    6
`define OC_CAP_BANK 5
`define OC_CMP_BANK 4
`define OC_OE_A     3
`define OC_OE_B     2
`define OC_LVL_A    1
`define OC_LVL_B    0
// Status word: flags in bits 7..1, clear-on-match enable in bit 0.
`define ST_CLR_A 0
// Halt bit inside module_halt_control.
`define HALT_BIT 13
// Reset values.
`define SETUP_RESET 8'h00
`define OUT_CTRL_RESET 8'h00
`define HALT_RESET 16'h3fff
`define CKS_EXT 2'h3
`endif

//--- verification/free_running_capture_compare_timer_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "frt_regs.svh"
module free_running_capture_compare_timer_tb;
   import frt_pkg::*;
   logic       clk        = 1'b0;
   logic       rst        = 1'b1;
   addr_t      addr       = 4'h0;
   word_t      wdata      = 16'h0000;
   logic       wr         = 1'b0;
   logic       rd         = 1'b0;
   word_t      rdata;
   logic       pulse      = 1'b0;
   logic [3:0] cap_lvl    = 4'h0;
   logic [3:0] cap_pin;
   logic       ext_clk;
   logic       pin_a;
   logic       pin_b;
   word_t      rdv;
   word_t      c1;
   logic       p1;
   word_t      step [3]   = '{16'h0020, 16'h0008, 16'h0002};
   int         errors     = 0;
   int         n_compared = 0;

   // Clock of 25 ns.
   always #12.5 clk = ~clk;

   free_running_capture_compare_timer i_dut (
      .i_core_clk           (clk),
      .i_rst                (rst),
      .i_addr               (addr),
      .i_wdata              (wdata),
      .i_wr                 (wr),
      .i_rd                 (rd),
      .o_rdata              (rdata),
      .i_capture_in_pin_a   (cap_pin[0]),
      .i_capture_in_pin_b   (cap_pin[1]),
      .i_capture_in_pin_c   (cap_pin[2]),
      .i_capture_in_pin_d   (cap_pin[3]),
      .i_ext_count_clock_pin(ext_clk),
      .o_compare_out_pin_a  (pin_a),
      .o_compare_out_pin_b  (pin_b)
   );

   frt_board_model board (
      .i_core_clk(clk),
      .i_pulse   (pulse),
      .i_cap_lvl (cap_lvl),
      .o_cap_pin (cap_pin),
      .o_ext_clk (ext_clk)
   );

   task automatic run(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic wr_reg(input addr_t a, input word_t d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe, so it is taken just past that edge.
   task automatic rd_reg(input addr_t a);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1;
      rdv = rdata;
   endtask

   task automatic pin_set(input int i, input logic v);
      @(posedge clk);
      cap_lvl[i] <= v;
      run(4);
   endtask

   task automatic ext(input int n);
      @(posedge clk);
      pulse <= 1'b1;
      run(4 * n - 1);
      pulse <= 1'b0;
      run(6);
   endtask

   task automatic cmp_word(input word_t got, input word_t exp);
      n_compared++;
      if (got !== exp)
      begin
         errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp_bit(input logic got, input logic exp);
      n_compared++;
      if (got !== exp)
      begin
         errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic stop_test();
      $display("compared %0d, mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // A hang is cut off well beyond the roughly one thousand cycles the tests need.
   initial
   begin
      run(20000);
      errors++;
      stop_test();
   end

   initial
   begin
      run(2);
      rst <= 1'b0;
      rd_reg(`ADDR_OUT_CTRL);
      cmp_word(rdv, 16'h0000);
      rd_reg(`ADDR_HALT);
      cmp_word(rdv, 16'h3fff);
      run(20);
      rd_reg(`ADDR_COUNTER);
      cmp_word(rdv, 16'h0000);
      rd_reg(4'hf);
      cmp_word(rdv, 16'h0000);
      $display("test reset done");
      // Reads 64 clocks apart see 64 divided by the selected ratio, whatever the divider phase.
      wr_reg(`ADDR_HALT, 16'h0000);
      for (int s = 0; s < 3; s++)
      begin
         wr_reg(`ADDR_SETUP, word_t'(s));
         run(40);
         rd_reg(`ADDR_COUNTER);
         c1 = rdv;
         run(62);
         rd_reg(`ADDR_COUNTER);
         cmp_word(rdv - c1, step[s]);
      end
      $display("test prescaler done");
      wr_reg(`ADDR_SETUP, 16'h0000);
      wr_reg(`ADDR_STATUS, 16'h0001);
      wr_reg(`ADDR_COMPARE, 16'h0040);
      wr_reg(`ADDR_OUT_CTRL, 16'h000a);
      wr_reg(`ADDR_COUNTER, 16'h0000);
      for (int i = 0; i < 400 && pin_a !== 1'b1; i++)
      begin
         @(posedge clk);
         #1;
      end
      cmp_bit(pin_a, 1'b1);
      cmp_bit(pin_b, 1'b0);
      rd_reg(`ADDR_COUNTER);
      cmp_bit(rdv < 16'h0010, 1'b1);
      rd_reg(`ADDR_STATUS);
      cmp_bit(rdv[3], 1'b1);
      wr_reg(`ADDR_OUT_CTRL, 16'h0002);
      #1;
      cmp_bit(pin_a, 1'b0);
      wr_reg(`ADDR_OUT_CTRL, 16'h0010);
      wr_reg(`ADDR_COMPARE, 16'h1234);
      wr_reg(`ADDR_OUT_CTRL, 16'h0000);
      rd_reg(`ADDR_COMPARE);
      cmp_word(rdv, 16'h0040);
      wr_reg(`ADDR_OUT_CTRL, 16'h0010);
      rd_reg(`ADDR_COMPARE);
      cmp_word(rdv, 16'h1234);
      $display("test compare done");
      // The external source with an idle pin freezes the counter, so captured values are exact.
      wr_reg(`ADDR_SETUP, 16'h0083);
      wr_reg(`ADDR_COUNTER, 16'h0100);
      pin_set(0, 1'b1);
      rd_reg(`ADDR_CAP_A);
      cmp_word(rdv, 16'h0100);
      pin_set(1, 1'b1);
      rd_reg(`ADDR_CAP_B);
      cmp_word(rdv, 16'h0000);
      wr_reg(`ADDR_COUNTER, 16'h0150);
      pin_set(1, 1'b0);
      rd_reg(`ADDR_CAP_B);
      cmp_word(rdv, 16'h0150);
      wr_reg(`ADDR_SETUP, 16'h0087);
      wr_reg(`ADDR_COUNTER, 16'h0200);
      pin_set(1, 1'b1);
      pin_set(1, 1'b0);
      rd_reg(`ADDR_CAP_B);
      cmp_word(rdv, 16'h0200);
      rd_reg(`ADDR_CAP_D);
      cmp_word(rdv, 16'h0150);
      wr_reg(`ADDR_SETUP, 16'h008f);
      wr_reg(`ADDR_COUNTER, 16'h0300);
      pin_set(0, 1'b0);
      rd_reg(`ADDR_CAP_A);
      cmp_word(rdv, 16'h0300);
      rd_reg(`ADDR_CAP_C);
      cmp_word(rdv, 16'h0100);
      pin_set(2, 1'b1);
      pin_set(2, 1'b0);
      rd_reg(`ADDR_CAP_C);
      cmp_word(rdv, 16'h0100);
      rd_reg(`ADDR_STATUS);
      cmp_bit(rdv[5], 1'b1);
      wr_reg(`ADDR_OUT_CTRL, 16'h0020);
      wr_reg(`ADDR_CAP_A, 16'h0abc);
      rd_reg(`ADDR_CAP_A);
      cmp_word(rdv, 16'h0abc);
      wr_reg(`ADDR_OUT_CTRL, 16'h0000);
      rd_reg(`ADDR_CAP_A);
      cmp_word(rdv, 16'h0300);
      $display("test capture done");
      ext(5);
      rd_reg(`ADDR_COUNTER);
      cmp_word(rdv, 16'h0305);
      wr_reg(`ADDR_COUNTER, 16'hfffe);
      ext(3);
      rd_reg(`ADDR_COUNTER);
      cmp_word(rdv, 16'h0001);
      rd_reg(`ADDR_STATUS);
      cmp_bit(rdv[1], 1'b1);
      wr_reg(`ADDR_STATUS, 16'h0000);
      rd_reg(`ADDR_STATUS);
      cmp_bit(rdv[1], 1'b0);
      wr_reg(`ADDR_HALT, 16'h2000);
      ext(5);
      rd_reg(`ADDR_COUNTER);
      cmp_word(rdv, 16'h0001);
      rd_reg(`ADDR_HALT);
      cmp_word(rdv, 16'h2000);
      $display("test external clock done");
      // Two add-mode matches bring compare A to 2 + 3 + 5 whichever level pin A starts from.
      wr_reg(`ADDR_HALT, 16'h0000);
      wr_reg(`ADDR_OUT_CTRL, 16'h0020);
      wr_reg(`ADDR_CAP_A, 16'h0003);
      wr_reg(`ADDR_CAP_B, 16'h0005);
      wr_reg(`ADDR_OUT_CTRL, 16'h0048);
      wr_reg(`ADDR_COUNTER, 16'h0000);
      wr_reg(`ADDR_COMPARE, 16'h0002);
      ext(3);
      p1 = pin_a;
      ext(5);
      cmp_bit(pin_a, ~p1);
      rd_reg(`ADDR_COMPARE);
      cmp_word(rdv, 16'h000a);
      // A mask width of 2 blocks capture D until the counter reaches capture D plus 4.
      wr_reg(`ADDR_SETUP, 16'h0093);
      wr_reg(`ADDR_OUT_CTRL, 16'h0020);
      wr_reg(`ADDR_CAP_C, 16'h0002);
      wr_reg(`ADDR_OUT_CTRL, 16'h0080);
      wr_reg(`ADDR_COUNTER, 16'h0010);
      pin_set(3, 1'b1);
      pin_set(3, 1'b0);
      wr_reg(`ADDR_COUNTER, 16'h0012);
      pin_set(3, 1'b1);
      rd_reg(`ADDR_CAP_D);
      cmp_word(rdv, 16'h0010);
      pin_set(3, 1'b0);
      wr_reg(`ADDR_COUNTER, 16'h0014);
      pin_set(3, 1'b1);
      rd_reg(`ADDR_CAP_D);
      cmp_word(rdv, 16'h0014);
      // Edge on pin A, count step and read of capture A share one cycle, so the late capture sees the step.
      wr_reg(`ADDR_COUNTER, 16'h0040);
      @(posedge clk);
      pulse      <= 1'b1;
      @(posedge clk);
      pulse      <= 1'b0;
      cap_lvl[0] <= 1'b1;
      addr       <= `ADDR_CAP_A;
      rd         <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      run(4);
      rd_reg(`ADDR_CAP_A);
      cmp_word(rdv, 16'h0041);
      $display("test modes done");
      stop_test();
   end
endmodule
`default_nettype wire

//--- verification/frt_board_model.sv
`timescale 1ns/10ps
`default_nettype none
module frt_board_model (
   input  wire logic       i_core_clk,
   input  wire logic       i_pulse,
   input  wire logic [3:0] i_cap_lvl,
   output logic [3:0]      o_cap_pin,
   output logic            o_ext_clk
);
   logic [1:0] width_r = 2'h0;

   // Each pulse stays high two clocks and low two clocks, so a request held for four clocks gives one pulse.
   always_ff @(posedge i_core_clk)
   begin
      if (width_r != 2'h0)
      begin
         width_r <= width_r - 2'h1;
      end
      else if (i_pulse)
      begin
         width_r <= 2'h3;
      end
   end

   // The clock pin idles low between pulses; capture pins follow the levels the bench asks for.
   assign o_ext_clk = width_r[1];
   assign o_cap_pin = i_cap_lvl;
endmodule
`default_nettype wire
